//--- logic/fbc_defs.vh
/*
 * fbc_defs.vh: timing figures and command codes for the parallel flash host controller.
 * assumes a 100 MHz controller clock; all times are in ns.
 */
`ifndef FBC_DEFS_VH
`define FBC_DEFS_VH
`define FBC_CLK_NS          10
`define FBC_ACC_NS          70
`define FBC_WR_NS           40
`define FBC_RP_NS           500
`define FBC_RH_NS           50
`define FBC_READY_NS        20000
`define FBC_CYC_MIN(ns)     (((ns) + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_OP_READ         2'h0
`define FBC_OP_WRITE        2'h1
`define FBC_OP_RESET        2'h2
`define FBC_UNLOCK_A1       20'h0_0555
`define FBC_UNLOCK_D1       16'h00AA
`define FBC_UNLOCK_A2       20'h0_02AA
`define FBC_UNLOCK_D2       16'h0055
`endif

//--- logic/fbc_host.v
/*
 * fbc_host.v: host-side bus controller for an asynchronous parallel nor flash.
 * it turns single read, write and reset requests into pin sequences on the
 * chip select, output enable, write enable, width select and reset pins.
 * assumes the flash pins are sampled asynchronously; ready_busy_n is
 * synchronised here. the testbench resolves the data bus from flash_dq_oe.
 */
// Functional notes
// RULE1 - read: select and output enable low, write high
// RULE2 - device drives data only under output enable
// RULE3 - width select picks word or byte reads
// RULE4 - after reset device reads array directly
// RULE5 - read mode persists until a command
// RULE6 - write: select and write low, output enable high
// RULE7 - program data width follows width select
// RULE8 - bypass mode programs with two writes
// RULE9 - erase by sector, sectors or chip
// RULE10 - identification codes read on low byte
// RULE11 - status bits read on low byte while busy
// RULE12 - standby: select and reset high, outputs float
// RULE13 - leaving standby needs normal access time
// RULE14 - deselect does not stop internal operation
// RULE15 - stable address gives automatic sleep, data held
// RULE16 - reset pulse aborts, floats outputs, ignores access
// RULE17 - host restarts interrupted operation after reset; fbc_host restarts nothing and only returns to idle after the reset
// RULE18 - reset while busy: wait ready-busy high
// RULE19 - reset while idle: short ready time
// RULE20 - wait recovery time before first read
// RULE21 - byte mode: bit fifteen is lowest address
// RULE22 - output enable high floats device outputs
// RULE23 - timing figures are parameters
`include "fbc_defs.vh"
`default_nettype none
module fbc_host #(
	parameter ACC_CYC   = `FBC_CYC_MIN(`FBC_ACC_NS),   // RULE23 read access cycles
	parameter WR_CYC    = `FBC_CYC_MIN(`FBC_WR_NS),    // write pulse cycles
	parameter RP_CYC    = `FBC_CYC_MIN(`FBC_RP_NS),    // reset pulse cycles
	parameter RH_CYC    = `FBC_CYC_MIN(`FBC_RH_NS),    // recovery cycles
	parameter READY_CYC = `FBC_CYC_MIN(`FBC_READY_NS)  // reset ready bound
) (
	input  wire        mclk,           // 100 MHz clock
	input  wire        nrst,           // async reset, active low
	input  wire        req_valid,      // request strobe
	input  wire [1:0]  req_op,         // read, write or reset
	input  wire [19:0] req_addr,       // byte address in byte mode, word otherwise
	input  wire [15:0] req_wdata,      // write data
	input  wire        req_byte,       // 1 = byte mode
	output reg         req_ready,      // idle, request accepted
	output reg         rsp_valid,      // one-cycle completion pulse
	output reg  [15:0] rsp_rdata,      // read data
	output reg         busy_seen,      // ready_busy_n low at last sample
	output reg  [18:0] flash_addr,     // address pins
	output reg  [15:0] flash_dq_o,     // data out
	output reg  [15:0] flash_dq_oe,    // per-bit output enable
	input  wire [15:0] flash_dq_i,     // data in
	output reg         flash_ce_n,     // chip select
	output reg         flash_oe_n,     // output enable
	output reg         flash_we_n,     // write enable
	output reg         flash_byte_n,   // width select, low = byte
	output reg         flash_reset_n,  // hardware reset
	input  wire        ready_busy_n    // device ready, low busy
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_READ  = 3'h1;
	localparam ST_WRITE = 3'h2;
	localparam ST_WHOLD = 3'h3;
	localparam ST_RST   = 3'h4;
	localparam ST_RDY   = 3'h5;
	localparam ST_REC   = 3'h6;

	reg  [2:0]  state_r;
	reg  [15:0] cnt_r;
	reg  [1:0]  rb_sync_r;
	reg  [15:0] rdata_r;
	reg         byte_r;
	reg  [15:0] dq_q1_r;
	reg  [15:0] dq_q2_r;

	// pick the count for a timed phase, at least one, truncated to 16 bits
	function [15:0] fbc_cyc;
		input integer c;
		begin
			fbc_cyc = (c < 1) ? 16'h0001 : c[15:0];
		end
	endfunction

	// two-flop synchronisers for asynchronous flash pins
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rb_sync_r <= 2'h0;
			dq_q1_r   <= 16'h0000;
			dq_q2_r   <= 16'h0000;
		end else begin
			rb_sync_r <= {rb_sync_r[0], ready_busy_n};
			dq_q1_r   <= flash_dq_i;
			dq_q2_r   <= dq_q1_r;
		end
	end

	// read data; byte mode keeps only the low byte, upper pins other than bit fifteen float
	always @* begin
		rdata_r = byte_r ? {8'h00, dq_q2_r[7:0]} : dq_q2_r; // RULE3 RULE10 RULE11
	end

	// sequencer; reset comes up by pulsing the flash reset so array read is known
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_r       <= ST_RST;
			// a short nrst pulse must still give the flash its full reset width
			cnt_r         <= fbc_cyc(RP_CYC); // RULE16
			req_ready     <= 1'b0;
			rsp_valid     <= 1'b0;
			rsp_rdata     <= 16'h0000;
			busy_seen     <= 1'b0;
			byte_r        <= 1'b0;
			flash_addr    <= 19'h0_0000;
			flash_dq_o    <= 16'h0000;
			flash_dq_oe   <= 16'h0000;
			flash_ce_n    <= 1'b1;
			flash_oe_n    <= 1'b1;
			flash_we_n    <= 1'b1;
			flash_byte_n  <= 1'b1;
			flash_reset_n <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			busy_seen <= ~rb_sync_r[1];
			case (state_r)
			ST_IDLE: begin
				// idle with select and reset high: device in standby
				flash_ce_n <= 1'b1; // RULE12 RULE14
				flash_oe_n <= 1'b1; // RULE22
				flash_we_n <= 1'b1;
				flash_dq_oe <= 16'h0000;
				if (req_valid && req_ready) begin
					req_ready    <= 1'b0;
					byte_r       <= req_byte;
					flash_byte_n <= ~req_byte; // RULE3 RULE7
					// byte mode: lowest address bit goes out on bit fifteen
					flash_addr   <= req_byte ? req_addr[19:1] : req_addr[18:0];
					flash_dq_o   <= req_byte ? {req_addr[0], 7'h00, req_wdata[7:0]}
					                         : req_wdata; // RULE21
					case (req_op)
					`FBC_OP_READ: begin
						flash_ce_n  <= 1'b0; // RULE1
						flash_oe_n  <= 1'b0; // RULE1 RULE2
						flash_dq_oe <= req_byte ? 16'h8000 : 16'h0000; // RULE21
						cnt_r       <= fbc_cyc(ACC_CYC + 2); // RULE13 RULE15
						state_r     <= ST_READ;
					end
					`FBC_OP_WRITE: begin
						// unlock, program, erase and bypass writes are all plain writes
						flash_ce_n  <= 1'b0; // RULE6 RULE8 RULE9
						flash_we_n  <= 1'b0; // RULE6
						flash_dq_oe <= req_byte ? 16'h80FF : 16'hFFFF; // RULE7
						cnt_r       <= fbc_cyc(WR_CYC);
						state_r     <= ST_WRITE;
					end
					default: begin
						flash_reset_n <= 1'b0; // RULE16
						cnt_r         <= fbc_cyc(RP_CYC);
						state_r       <= ST_RST;
					end
					endcase
				end else begin
					req_ready <= 1'b1;
				end
			end
			ST_READ: begin
				// extra two cycles cover the data synchroniser
				if (cnt_r == 16'h0001) begin
					flash_ce_n  <= 1'b1;
					flash_oe_n  <= 1'b1;
					flash_dq_oe <= 16'h0000;
					rsp_rdata   <= rdata_r; // RULE5
					rsp_valid   <= 1'b1;
					state_r     <= ST_IDLE;
				end else begin
					cnt_r <= cnt_r - 16'h0001;
				end
			end
			ST_WRITE: begin
				if (cnt_r == 16'h0001) begin
					flash_we_n <= 1'b1; // data latched on the rising edge
					state_r    <= ST_WHOLD;
				end else begin
					cnt_r <= cnt_r - 16'h0001;
				end
			end
			ST_WHOLD: begin
				// one cycle of data hold before releasing the bus
				flash_ce_n  <= 1'b1;
				flash_dq_oe <= 16'h0000;
				rsp_valid   <= 1'b1;
				state_r     <= ST_IDLE;
			end
			ST_RST: begin
				flash_reset_n <= 1'b0;
				flash_ce_n    <= 1'b1;
				flash_dq_oe   <= 16'h0000; // RULE16
				if (cnt_r <= 16'h0001) begin
					flash_reset_n <= 1'b1;
					cnt_r         <= fbc_cyc(READY_CYC);
					state_r       <= ST_RDY;
				end else begin
					cnt_r <= cnt_r - 16'h0001;
				end
			end
			ST_RDY: begin
				// busy holds until the internal reset ends; bound covers both cases
				if (rb_sync_r[1] || cnt_r == 16'h0001) begin // RULE18 RULE19
					cnt_r   <= fbc_cyc(RH_CYC);
					state_r <= ST_REC;
				end else begin
					cnt_r <= cnt_r - 16'h0001;
				end
			end
			ST_REC: begin
				if (cnt_r == 16'h0001) begin // RULE20 RULE4
					rsp_valid <= 1'b1;
					state_r   <= ST_IDLE;
				end else begin
					cnt_r <= cnt_r - 16'h0001;
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // fbc_host
`default_nettype wire

//--- tb/fbc_chk.sv
/* fbc_chk: pin checks on the flash side of fbc_host. assumes a bind onto its ports. */
`default_nettype none
module fbc_chk (
	input wire logic        mclk,          // clk
	input wire logic        nrst,          // reset
	input wire logic [18:0] flash_addr,    // addr
	input wire logic        flash_ce_n,    // select
	input wire logic        flash_oe_n,    // out en
	input wire logic        flash_we_n,    // wr en
	input wire logic        flash_reset_n  // hw reset
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	// strobe levels per access kind; overlap would make the device see a write in a read
	a_read_strobes: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n)
		else $error("read strobes wrong");
	a_read_addr_hold: assert property (!flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr))
		else $error("address moved in read");
	a_write_strobes: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
		else $error("write strobes wrong");
	a_recover_gap: assert property ($rose(flash_reset_n) |-> flash_oe_n [*4])
		else $error("read too soon after reset");
	a_reset_pulse: assert property ($fell(flash_reset_n) |=> !flash_reset_n)
		else $error("reset pulse too short");
	c_read: cover property (!flash_oe_n);
	c_write: cover property (!flash_we_n);
	c_reset: cover property ($rose(flash_reset_n));
endmodule // fbc_chk
`default_nettype wire

//--- tb/fbc_flash.sv
/* fbc_flash: behavioural nor flash, 64-byte array. assumes the bench resolves the bus. */
`default_nettype none
module fbc_flash (
	input  wire logic [18:0] flash_addr,    // addr
	input  wire logic [15:0] dq_in,         // bus
	output var  logic [15:0] dq_out,        // drive
	input  wire logic        flash_ce_n,    // select
	input  wire logic        flash_oe_n,    // out en
	input  wire logic        flash_we_n,    // wr en
	input  wire logic        flash_byte_n,  // width
	input  wire logic        flash_reset_n, // reset
	output var  logic        ready_busy_n   // busy low
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mem [0:63];
	logic [23:0] hist;
	logic [7:0]  pdat;
	logic [5:0]  ba;
	logic [15:0] rd;
	event        prog_ev;
	// array comes up readable with no command
	initial begin
		for (int i = 0; i < 64; i++) mem[i] = 8'h5a ^ 8'(i);
	end
	// byte index; in byte mode bit fifteen is the lowest address
	assign ba = {flash_addr[4:0], flash_byte_n ? 1'b0 : dq_in[15]};
	// status while busy, else array; floated lines read inverted, not held
	assign rd = !ready_busy_n ? {8'h00, ~pdat[7], 7'h00} : {mem[ba | 1], mem[ba]};
	always @* begin
		if (!flash_ce_n && !flash_oe_n && flash_we_n && flash_reset_n)
			dq_out = flash_byte_n ? rd : {~rd[15:8], rd[7:0]};
		else
			dq_out = ~rd;
	end
	// fourth write after the unlock pair and program code stores one unit
	always @(posedge flash_we_n or negedge flash_reset_n) begin
		if (!flash_reset_n)
			hist <= 24'h00_0000;
		else if (hist == 24'haa_55a0) begin
			mem[ba] <= dq_in[7:0];
			if (flash_byte_n)
				mem[ba | 1] <= dq_in[15:8];
			pdat <= dq_in[7:0];
			hist <= 24'h00_0000;
			-> prog_ev;
		end else
			hist <= {hist[15:0], dq_in[7:0]};
	end
	// deselect does not stop the operation; one process owns the busy pin
	always begin
		ready_busy_n = 1'b1;
		@(prog_ev);
		ready_busy_n = 1'b0;
		#300;
	end
endmodule // fbc_flash
`default_nettype wire

//--- tb/fbc_host_tb_top.sv
/* fbc_host_tb_top: directed bench for fbc_host. assumes fbc_flash as the device. */
`default_nettype none
module fbc_host_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, nrst = 0, req_valid = 0, req_byte = 0;
	logic [1:0] req_op = 0;
	logic [19:0] req_addr = 0;
	logic [15:0] req_wdata = 0;
	wire logic req_ready, rsp_valid, busy_seen, flash_ce_n, flash_oe_n, flash_we_n;
	wire logic flash_byte_n, flash_reset_n, ready_busy_n;
	wire logic [18:0] flash_addr;
	wire logic [15:0] rsp_rdata, flash_dq_o, flash_dq_oe, flash_dq_i, dev_dq;
	int err_count = 0, comparisons = 0, n;
	// bus level: host bits where it drives, device elsewhere
	assign flash_dq_i = (flash_dq_oe & flash_dq_o) | (~flash_dq_oe & dev_dq);
	fbc_host #(.RP_CYC(2), .READY_CYC(20), .RH_CYC(1)) dut (.mclk, .nrst, .req_valid, .req_op,
		.req_addr, .req_wdata, .req_byte, .req_ready, .rsp_valid, .rsp_rdata, .busy_seen,
		.flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i, .flash_ce_n, .flash_oe_n,
		.flash_we_n, .flash_byte_n, .flash_reset_n, .ready_busy_n);
	fbc_flash u_flash (.flash_addr, .dq_in(flash_dq_i), .dq_out(dev_dq), .flash_ce_n,
		.flash_oe_n, .flash_we_n, .flash_byte_n, .flash_reset_n, .ready_busy_n);
	initial forever #5 mclk = ~mclk;
	function automatic logic [7:0] pat(input int i);
		return 8'h5a ^ 8'(i);
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("err_count=%0d comparisons=%0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// one cycle of a bounded wait; a hang ends the run
	task automatic tick;
		@(negedge mclk);
		n++;
		if (n > 5000) begin
			err_count++;
			summarize;
		end
	endtask
	// one request; the strobe holds until the take edge has passed
	task automatic xfer(input logic [1:0] op, input logic [19:0] a, input logic [15:0] d,
		input logic b);
		n = 0;
		while (req_ready !== 1'b1) tick;
		{req_op, req_addr, req_wdata, req_byte, req_valid} = {op, a, d, b, 1'b1};
		@(negedge mclk);
		req_valid = 0;
		while (rsp_valid !== 1'b1) tick;
	endtask
	task automatic rd(input logic [19:0] a, input logic b, input logic [15:0] exp);
		xfer(0, a, 0, b);
		chk(rsp_rdata, exp);
	endtask
	// busy shows three cycles after the write ends: wait for it to rise, then clear
	task automatic wait_ready;
		n = 0;
		while (busy_seen !== 1'b1) tick;
		while (busy_seen !== 1'b0) tick;
	endtask
	task automatic unlock(input logic b);
		xfer(1, 20'h0_0555, 16'h00aa, b);
		xfer(1, 20'h0_02aa, 16'h0055, b);
	endtask
	task automatic t_boot;
		n = 0;
		while (rsp_valid !== 1'b1) tick;
		chk({15'h0000, busy_seen}, 16'h0000);
		rd(20'h0_0003, 0, {pat(7), pat(6)});
		rd(20'h0_0009, 1, {8'h00, pat(9)});
		rd(20'h0_0008, 1, {8'h00, pat(8)});
	endtask
	task automatic t_prog;
		unlock(0);
		xfer(1, 20'h0_0555, 16'h00a0, 0);
		xfer(1, 20'h0_0004, 16'h1234, 0);
		rd(20'h0_0004, 0, 16'h0080);
		wait_ready;
		rd(20'h0_0004, 0, 16'h1234);
		unlock(1);
		xfer(1, 20'h0_0555, 16'h00a0, 1);
		xfer(1, 20'h0_000b, 16'h00c3, 1);
		wait_ready;
		rd(20'h0_000b, 1, 16'h00c3);
		rd(20'h0_000a, 1, {8'h00, pat(10)});
	endtask
	// reset in mid-sequence drops the partial command
	task automatic t_reset;
		unlock(0);
		xfer(2, 0, 0, 0);
		xfer(1, 20'h0_0555, 16'h00a0, 0);
		xfer(1, 20'h0_0006, 16'h0000, 0);
		rd(20'h0_0006, 0, {pat(13), pat(12)});
	endtask
	initial begin
		repeat (20) @(negedge mclk);
		nrst = 1;
		t_boot;
		t_prog;
		t_reset;
		summarize;
	end
endmodule // fbc_host_tb_top
bind fbc_host fbc_chk u_chk (.mclk, .nrst, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n,
	.flash_reset_n);
`default_nettype wire
